/* File: src/buck_channel_sequencer_protect.sv */
// Four-channel sequencing, ramp and protection control for the step-down controller.
`timescale 1ns/1ps

// Notes on behaviour
// - Reference target equals the target code times 50 mV.
// - Over-voltage checking runs in every active state, ramp included.
// - Over-voltage trip shuts the channel, then sets its fault flag.
// - Over-voltage margin 150-300 mV low range, 300-600 mV high range.
// - Channels following an over-voltage channel are disabled at the same time.
// - Over-voltage shut channels stay off until the host re-enables them.
// - Fault and warning flags of each channel with FLAG_PIN_ROUTE set are ORed onto its pin.
// - Per-channel style: passive stop or forced low-side drive.
// - Forced style holds low-side drive until the host re-enables.
// - Sensed current compared to limit and warning thresholds separately.
// - Current limit register: bits 5:0 threshold, bits 7:6 warning offset.
// - Threshold steps of 5 mV sense voltage, 0 to 315 mV.
// - Warning threshold sits 10, 20, 30 or 40 mV below limit.
// - Warning flag follows current and clears itself.
// - Over-current stops switching, waits 200 ms, then runs the enable delay and soft-start again.
// - Over-current restarts followers too and sets fault flags.
// - Enable waits bits 15:10 times 250 us before switching.
// - Soft-start raises reference 50 mV every bits 9:0 microseconds.
// - Disable waits bits 15:10 times 250 us before ramping down.
// - Soft-stop lowers reference 50 mV every bits 9:0 microseconds.
// - Chip enable raises ready and enables always-on channels.
module buck_channel_sequencer_protect
   import buck_seq_pkg::*;
#(
   parameter int RESTART_WAIT_US = RESTART_US
)(
   input  wire logic                        CLK_SYS,
   input  wire logic                        SYS_RST,
   input  wire logic                        CHIP_ENABLE,
   input  wire cfg_write_type               CFG_WRITE,
   input  wire logic [NUM_CH-1:0]           CHANNEL_ENABLE,
   input  wire logic [NUM_CH-1:0]           ALWAYS_ON,
   input  wire logic [NUM_CH*NUM_CH-1:0]    FOLLOW_CONFIG,
   input  wire logic [NUM_CH*TARGET_W-1:0]  VOLTAGE_SENSE,
   input  wire logic [NUM_CH*SENSE_W-1:0]   CURRENT_SENSE,
   input  wire logic [NUM_CH-1:0]           FLAG_PIN_ROUTE,
   output      logic                        CHIP_READY,
   output      logic [NUM_CH*TARGET_W-1:0]  REFERENCE_CODE,
   output      logic [NUM_CH-1:0]           SWITCHING_ON,
   output      logic [NUM_CH-1:0]           LOW_SIDE_GATE_DRIVE,
   output      ch_flags_type [NUM_CH-1:0]   FLAGS,
   output      logic [NUM_CH-1:0]           FLAG_PIN
);

   logic                           tick_us;
   logic [7:0]                     target_reg     [NUM_CH];
   logic [7:0]                     limit_reg      [NUM_CH];
   logic [15:0]                    ramp_up_reg    [NUM_CH];
   logic [15:0]                    ramp_down_reg  [NUM_CH];
   logic [1:0]                     ov_thr_reg     [NUM_CH];
   logic [NUM_CH-1:0]              style_reg;
   ch_state_type                   state_reg      [NUM_CH];
   logic [7:0]                     ref_reg        [NUM_CH];
   logic [17:0]                    count_reg      [NUM_CH];
   logic [NUM_CH-1:0]              en_d_reg;
   logic [NUM_CH-1:0]              ov_trip;
   logic [NUM_CH-1:0]              oc_trip;
   logic [NUM_CH-1:0]              warn_now;
   logic [NUM_CH-1:0]              ov_kill;
   logic [NUM_CH-1:0]              oc_kill;
   logic [NUM_CH-1:0]              want_on;

   buck_tick_gen u_tick (
      .clk     (CLK_SYS),
      .rst     (SYS_RST),
      .tick_us (tick_us)
   );

   // Chip ready follows chip enable.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         CHIP_READY <= 1'b0;
      end else begin
         CHIP_READY <= CHIP_ENABLE;
      end
   end

   // Configuration register writes.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         for (int i = 0; i < NUM_CH; i++) begin
            target_reg[i]    <= TARGET_RST;
            limit_reg[i]     <= LIMIT_RST;
            ramp_up_reg[i]   <= RAMP_RST;
            ramp_down_reg[i] <= RAMP_RST;
            ov_thr_reg[i]    <= OV_THR_RST;
         end
         style_reg <= '0;
      end else if (CFG_WRITE.strobe) begin
         unique case (CFG_WRITE.select)
            SEL_TARGET:    target_reg[CFG_WRITE.channel] <= CFG_WRITE.data[7:0];
            SEL_LIMIT:     limit_reg[CFG_WRITE.channel] <= CFG_WRITE.data[7:0];
            SEL_RAMP_UP:   ramp_up_reg[CFG_WRITE.channel] <= CFG_WRITE.data;
            SEL_RAMP_DOWN: ramp_down_reg[CFG_WRITE.channel] <= CFG_WRITE.data;
            SEL_OV_THR:    ov_thr_reg[CFG_WRITE.channel] <= CFG_WRITE.data[1:0];
            SEL_STYLE:     style_reg[CFG_WRITE.channel] <= CFG_WRITE.data[0];
            default: ;
         endcase
      end
   end

   // Protection comparisons per channel, in millivolt and 5 mV code domains.
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         logic [13:0] ov_lim_mv; // Wide enough for a full code plus margin, so no wrap.
         logic [13:0] sense_mv;
         logic [6:0]  thr;
         logic [6:0]  wthr;
         logic [6:0]  cur;
         ov_lim_mv = 14'(target_reg[i] * TARGET_STEP_MV);
         if (target_reg[i] >= HIGH_RANGE_CODE) begin
            ov_lim_mv = ov_lim_mv + 14'(OV_HIGH_BASE_MV + ov_thr_reg[i] * OV_HIGH_STEP_MV);
         end else begin
            ov_lim_mv = ov_lim_mv + 14'(OV_LOW_BASE_MV + ov_thr_reg[i] * OV_LOW_STEP_MV);
         end
         sense_mv = 14'(VOLTAGE_SENSE[i*TARGET_W +: TARGET_W] * TARGET_STEP_MV);
         ov_trip[i] = (state_reg[i] inside {CH_DELAY, CH_RAMP_UP, CH_ON, CH_STOP_DELAY,
                       CH_RAMP_DOWN}) && (sense_mv > ov_lim_mv);
         thr  = {1'b0, limit_reg[i][LIMIT_THR_MSB:LIMIT_THR_LSB]};
         wthr = thr - 7'((limit_reg[i][LIMIT_WRN_MSB:LIMIT_WRN_LSB] + 1) * WARN_STEP_CODE);
         cur  = 7'(CURRENT_SENSE[i*SENSE_W +: SENSE_W] > 8'h3f ? 8'h3f
                   : CURRENT_SENSE[i*SENSE_W +: SENSE_W]);
         oc_trip[i]  = (state_reg[i] inside {CH_RAMP_UP, CH_ON}) && (cur >= thr);
         warn_now[i] = !wthr[6] && (cur >= wthr);
      end
   end

   // Spread faults to follower channels; FOLLOW_CONFIG[f*4+l] marks f following l.
   always_comb begin
      for (int f = 0; f < NUM_CH; f++) begin
         ov_kill[f] = ov_trip[f];
         oc_kill[f] = oc_trip[f];
         for (int l = 0; l < NUM_CH; l++) begin
            if (FOLLOW_CONFIG[f*NUM_CH+l] && ov_trip[l]) begin
               ov_kill[f] = 1'b1;
            end
            if (FOLLOW_CONFIG[f*NUM_CH+l] && oc_trip[l]) begin
               oc_kill[f] = 1'b1;
            end
         end
         want_on[f] = CHIP_ENABLE && (CHANNEL_ENABLE[f] || ALWAYS_ON[f]);
      end
   end

   // Channel sequencers.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         for (int i = 0; i < NUM_CH; i++) begin
            state_reg[i] <= CH_OFF;
            ref_reg[i]   <= '0;
            count_reg[i] <= '0;
         end
         en_d_reg <= '0;
      end else begin
         en_d_reg <= want_on;
         for (int i = 0; i < NUM_CH; i++) begin
            if (ov_kill[i] && state_reg[i] != CH_OV_OFF && state_reg[i] != CH_OFF) begin
               state_reg[i] <= CH_OV_OFF;
               ref_reg[i]   <= '0;
            end else if (oc_kill[i] && state_reg[i] != CH_OV_OFF && state_reg[i] != CH_OFF) begin
               state_reg[i] <= CH_OC_WAIT;
               ref_reg[i]   <= '0;
               count_reg[i] <= '0;
            end else begin
               unique case (state_reg[i])
                  CH_OFF: begin
                     if (want_on[i]) begin
                        state_reg[i] <= CH_DELAY;
                        count_reg[i] <= '0;
                     end
                  end
                  CH_DELAY: begin
                     if (!want_on[i]) begin
                        state_reg[i] <= CH_OFF;
                     end else if (count_reg[i] >= 18'(ramp_up_reg[i][RAMP_DLY_MSB:RAMP_DLY_LSB]
                                  * DLY_STEP_US)) begin
                        state_reg[i] <= CH_RAMP_UP;
                        count_reg[i] <= '0;
                     end else if (tick_us) begin
                        count_reg[i] <= count_reg[i] + 1'b1;
                     end
                  end
                  CH_RAMP_UP: begin
                     if (!want_on[i]) begin
                        state_reg[i] <= CH_STOP_DELAY;
                        count_reg[i] <= '0;
                     end else if (ref_reg[i] >= target_reg[i]) begin
                        ref_reg[i]   <= target_reg[i];
                        state_reg[i] <= CH_ON;
                     end else if (tick_us) begin
                        if (count_reg[i] + 1'b1 >= 18'(ramp_up_reg[i][RAMP_STEP_MSB:RAMP_STEP_LSB])) begin
                           ref_reg[i]   <= ref_reg[i] + 1'b1;
                           count_reg[i] <= '0;
                        end else begin
                           count_reg[i] <= count_reg[i] + 1'b1;
                        end
                     end
                  end
                  CH_ON: begin
                     ref_reg[i] <= target_reg[i];
                     if (!want_on[i]) begin
                        state_reg[i] <= CH_STOP_DELAY;
                        count_reg[i] <= '0;
                     end
                  end
                  CH_STOP_DELAY: begin
                     if (count_reg[i] >= 18'(ramp_down_reg[i][RAMP_DLY_MSB:RAMP_DLY_LSB]
                         * DLY_STEP_US)) begin
                        state_reg[i] <= CH_RAMP_DOWN;
                        count_reg[i] <= '0;
                     end else if (tick_us) begin
                        count_reg[i] <= count_reg[i] + 1'b1;
                     end
                  end
                  CH_RAMP_DOWN: begin
                     if (ref_reg[i] == '0) begin
                        state_reg[i] <= CH_OFF;
                     end else if (tick_us) begin
                        if (count_reg[i] + 1'b1 >= 18'(ramp_down_reg[i][RAMP_STEP_MSB:RAMP_STEP_LSB])) begin
                           ref_reg[i]   <= ref_reg[i] - 1'b1;
                           count_reg[i] <= '0;
                        end else begin
                           count_reg[i] <= count_reg[i] + 1'b1;
                        end
                     end
                  end
                  CH_OC_WAIT: begin
                     if (count_reg[i] >= 18'(RESTART_WAIT_US)) begin
                        state_reg[i] <= CH_DELAY;
                        count_reg[i] <= '0;
                     end else if (tick_us) begin
                        count_reg[i] <= count_reg[i] + 1'b1;
                     end
                  end
                  CH_OV_OFF: begin
                     if (want_on[i] && !en_d_reg[i]) begin
                        state_reg[i] <= CH_DELAY;
                        count_reg[i] <= '0;
                     end
                  end
               endcase
            end
         end
      end
   end

   // Sticky fault flags, live warning flag, pins and drive outputs.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         FLAGS               <= '0;
         FLAG_PIN            <= '0;
         REFERENCE_CODE      <= '0;
         SWITCHING_ON        <= '0;
         LOW_SIDE_GATE_DRIVE <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (state_reg[i] == CH_OV_OFF) begin
               FLAGS[i].ov_fault <= 1'b1;
            end else if (state_reg[i] == CH_DELAY) begin
               FLAGS[i].ov_fault <= 1'b0;
            end
            if (oc_kill[i]) begin
               FLAGS[i].oc_fault <= 1'b1;
            end else if (state_reg[i] == CH_ON) begin
               FLAGS[i].oc_fault <= 1'b0;
            end
            FLAGS[i].oc_warn <= warn_now[i];
            FLAG_PIN[i] <= FLAG_PIN_ROUTE[i] && (FLAGS[i].ov_fault || FLAGS[i].oc_fault
                           || FLAGS[i].oc_warn);
            REFERENCE_CODE[i*TARGET_W +: TARGET_W] <= ref_reg[i];
            SWITCHING_ON[i] <= state_reg[i] inside {CH_RAMP_UP, CH_ON, CH_STOP_DELAY,
                               CH_RAMP_DOWN};
            LOW_SIDE_GATE_DRIVE[i] <= (state_reg[i] == CH_OV_OFF) && style_reg[i];
         end
      end
   end

endmodule // buck_channel_sequencer_protect

/* File: src/buck_seq_pkg.sv */
// Package with register layouts, encodings and timing constants for the channel sequencer.
package buck_seq_pkg;

   localparam int NUM_CH = 4;

   // Register widths and fields.
   localparam int TARGET_W    = 8;
   localparam int LIMIT_THR_LSB = 0;
   localparam int LIMIT_THR_MSB = 5;
   localparam int LIMIT_WRN_LSB = 6;
   localparam int LIMIT_WRN_MSB = 7;
   localparam int RAMP_DLY_LSB  = 10;
   localparam int RAMP_DLY_MSB  = 15;
   localparam int RAMP_STEP_LSB = 0;
   localparam int RAMP_STEP_MSB = 9;
   localparam int SENSE_W       = 8;

   // Register select codes on the configuration write port.
   localparam logic [2:0] SEL_TARGET    = 3'h0;
   localparam logic [2:0] SEL_LIMIT     = 3'h1;
   localparam logic [2:0] SEL_RAMP_UP   = 3'h2;
   localparam logic [2:0] SEL_RAMP_DOWN = 3'h3;
   localparam logic [2:0] SEL_OV_THR    = 3'h4;
   localparam logic [2:0] SEL_STYLE     = 3'h5;

   // Reset values of the configuration.
   localparam logic [7:0]  TARGET_RST = 8'h00;
   localparam logic [7:0]  LIMIT_RST  = 8'hff;
   localparam logic [15:0] RAMP_RST   = 16'h0000;
   localparam logic [1:0]  OV_THR_RST = 2'h0;

   // Step sizes in millivolts, and warning offset step in threshold codes.
   localparam int TARGET_STEP_MV = 50;
   localparam int LIMIT_STEP_MV  = 5;
   localparam int WARN_STEP_MV   = 10;
   localparam int WARN_STEP_CODE = WARN_STEP_MV / LIMIT_STEP_MV;
   // Over-voltage margin in millivolts: low range base 150, high range base 300.
   localparam int OV_LOW_BASE_MV  = 150;
   localparam int OV_HIGH_BASE_MV = 300;
   localparam int OV_LOW_STEP_MV  = 50;
   localparam int OV_HIGH_STEP_MV = 100;
   localparam logic [7:0] HIGH_RANGE_CODE = 8'h34;

   // Timing.
   localparam int CLK_HZ          = 20_000_000;
   localparam int US_NS           = 1000;
   localparam int CLK_NS          = 1_000_000_000 / CLK_HZ;
   localparam int US_CYCLES       = US_NS / CLK_NS;
   localparam int DLY_STEP_US     = 250;
   localparam int RESTART_MS      = 200;
   localparam int RESTART_US      = RESTART_MS * 1000;

   typedef enum logic [2:0] {
      CH_OFF, CH_DELAY, CH_RAMP_UP, CH_ON, CH_STOP_DELAY, CH_RAMP_DOWN, CH_OC_WAIT, CH_OV_OFF
   } ch_state_type;

   // Write request on the configuration port.
   typedef struct packed {
      logic       strobe;
      logic [1:0] channel;
      logic [2:0] select;
      logic [15:0] data;
   } cfg_write_type;

   // Status of one channel.
   typedef struct packed {
      logic ov_fault;
      logic oc_fault;
      logic oc_warn;
   } ch_flags_type;

endpackage

/* File: src/buck_tick_gen.sv */
// Microsecond tick prescaler shared by the channel timers.
`timescale 1ns/1ps
module buck_tick_gen
   import buck_seq_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   output      logic tick_us
);

   logic [$clog2(US_CYCLES)-1:0] div_reg;

   // Count system clocks and pulse once each microsecond.
   always_ff @(posedge clk) begin
      if (rst) begin
         div_reg <= '0;
         tick_us <= 1'b0;
      end else if (div_reg == ($clog2(US_CYCLES))'(US_CYCLES - 1)) begin
         div_reg <= '0;
         tick_us <= 1'b1;
      end else begin
         div_reg <= div_reg + 1'b1;
         tick_us <= 1'b0;
      end
   end

endmodule // buck_tick_gen

/* File: verif/buck_channel_sequencer_protect_tb.sv */
// Self-checking testbench for the channel sequencer and protection block.
`timescale 1ns/1ps
module buck_channel_sequencer_protect_tb;
   import buck_seq_pkg::*;

   logic                       clk = 1'b0;
   logic                       rst;
   logic                       chip_en;
   cfg_write_type              cfg;
   logic [NUM_CH-1:0]          ch_en;
   logic [NUM_CH-1:0]          always_on;
   logic [NUM_CH*NUM_CH-1:0]   follow;
   logic [NUM_CH*TARGET_W-1:0] vsense;
   logic [NUM_CH*SENSE_W-1:0]  isense;
   logic [NUM_CH-1:0]          route;
   logic                       ready;
   logic [NUM_CH*TARGET_W-1:0] ref_code;
   logic [NUM_CH-1:0]          sw;
   logic [NUM_CH-1:0]          gate;
   ch_flags_type [NUM_CH-1:0]  flags;
   logic [NUM_CH-1:0]          flag_pin;
   int                         n_errors = 0;
   int                         tests_run = 0;
   string names[8] = '{"switching", "reference", "gate", "ov_fault", "oc_fault", "oc_warn",
                       "flag_pin", "ready"};

   always #25 clk = ~clk;

   buck_host_model host (.clk(clk), .cfg(cfg));

   buck_channel_sequencer_protect #(.RESTART_WAIT_US(20)) dut (
      .CLK_SYS(clk), .SYS_RST(rst), .CHIP_ENABLE(chip_en), .CFG_WRITE(cfg),
      .CHANNEL_ENABLE(ch_en), .ALWAYS_ON(always_on), .FOLLOW_CONFIG(follow),
      .VOLTAGE_SENSE(vsense), .CURRENT_SENSE(isense), .FLAG_PIN_ROUTE(route),
      .CHIP_READY(ready), .REFERENCE_CODE(ref_code), .SWITCHING_ON(sw),
      .LOW_SIDE_GATE_DRIVE(gate), .FLAGS(flags), .FLAG_PIN(flag_pin));

   // Picks one observed output of one channel.
   function automatic logic [15:0] probe(input int kind, input int ch);
      case (kind)
         0: probe = {15'h0, sw[ch]};
         1: probe = {8'h0, ref_code[ch*8 +: 8]};
         2: probe = {15'h0, gate[ch]};
         3: probe = {15'h0, flags[ch].ov_fault};
         4: probe = {15'h0, flags[ch].oc_fault};
         5: probe = {15'h0, flags[ch].oc_warn};
         6: probe = {15'h0, flag_pin[ch]};
         default: probe = {15'h0, ready};
      endcase
   endfunction

   task automatic check(input int kind, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", names[kind], exp, got);
      end
   endtask

   // Waits up to lim cycles for a value, then compares.
   task automatic wait_for(input int kind, input int ch, input logic [15:0] exp, input int lim);
      int n;
      n = 0;
      while (probe(kind, ch) !== exp && n < lim) begin
         @(negedge clk);
         n++;
      end
      check(kind, exp, probe(kind, ch));
   endtask

   // Demands that a value stands for cyc cycles.
   task automatic hold(input int kind, input int ch, input logic [15:0] exp, input int cyc);
      logic [15:0] seen;
      seen = exp;
      repeat (cyc) begin
         @(negedge clk);
         if (probe(kind, ch) !== exp) seen = probe(kind, ch);
      end
      check(kind, exp, seen);
   endtask

   task automatic tally_and_finish;
      if (n_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog sized well above the longest path through the tests.
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end

   // Main sequence: start-up, over-voltage margins, warning, over-current, over-voltage, soft-stop.
   initial begin
      rst = 1'b1;
      chip_en = 1'b0;
      ch_en = '0;
      always_on = '0;
      follow = 16'h0010;  // Channel 1 follows channel 0.
      vsense = '0;
      isense = '0;
      route = 4'h1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      wait_for(7, 0, 16'h0, 0);
      chip_en = 1'b1;
      wait_for(7, 0, 16'h1, 3);
      host.set_target(0, 2500);
      host.set_target(1, 2650);
      host.set_target(2, 5500);
      host.write_reg(0, SEL_LIMIT, 16'h0054);
      host.write_reg(0, SEL_RAMP_UP, 16'h0401);
      host.write_reg(1, SEL_RAMP_UP, 16'h0001);
      host.write_reg(1, SEL_RAMP_DOWN, 16'h0401);
      host.write_reg(0, SEL_STYLE, 16'h0001);
      host.write_reg(1, SEL_OV_THR, 16'h0001);
      host.write_reg(2, SEL_OV_THR, 16'h0003);
      always_on = 4'h4;
      wait_for(1, 2, 16'h32, 1300);
      ch_en = 4'h3;
      wait_for(0, 1, 16'h1, 100);
      hold(0, 0, 16'h0, 4900);
      wait_for(0, 0, 16'h1, 300);
      wait_for(1, 0, 16'h32, 1300);
      hold(1, 0, 16'h32, 200);
      wait_for(1, 1, 16'h34, 100);
      // High range with select 1 allows 400 mV; low range with select 3 allows 300 mV.
      vsense[15:8] = 8'h3c;
      vsense[23:16] = 8'h38;
      hold(3, 1, 16'h0, 5);
      hold(3, 2, 16'h0, 1);
      vsense[23:16] = 8'h39;
      wait_for(3, 2, 16'h1, 3);
      wait_for(0, 2, 16'h0, 0);
      vsense[15:8] = 8'h00;
      // Warning threshold is 20 mV under a 100 mV limit.
      isense[7:0] = 8'd16;
      wait_for(5, 0, 16'h1, 3);
      wait_for(6, 0, 16'h1, 3);
      isense[7:0] = 8'd15;
      wait_for(5, 0, 16'h0, 3);
      isense[7:0] = 8'd19;
      hold(4, 0, 16'h0, 5);
      isense[7:0] = 8'd20;
      wait_for(4, 0, 16'h1, 3);
      isense[7:0] = 8'd0;
      wait_for(0, 0, 16'h0, 3);
      wait_for(0, 1, 16'h0, 3);
      hold(0, 1, 16'h0, 370);
      wait_for(0, 1, 16'h1, 100);
      wait_for(0, 0, 16'h1, 5400);
      wait_for(1, 0, 16'h32, 1100);
      wait_for(4, 0, 16'h0, 3);
      // Over-voltage margin is three codes in the low range.
      vsense[7:0] = 8'h34;
      hold(3, 0, 16'h0, 5);
      vsense[7:0] = 8'h36;
      wait_for(3, 0, 16'h1, 3);
      wait_for(0, 0, 16'h0, 0);
      wait_for(2, 0, 16'h1, 2);
      wait_for(0, 1, 16'h0, 3);
      wait_for(2, 1, 16'h0, 0);
      vsense[7:0] = 8'h32;
      hold(2, 0, 16'h1, 600);
      wait_for(0, 1, 16'h0, 0);
      ch_en = 4'h0;
      repeat (2) @(negedge clk);
      ch_en = 4'h3;
      wait_for(2, 0, 16'h0, 3);
      wait_for(0, 1, 16'h1, 100);
      wait_for(1, 1, 16'h34, 1100);
      ch_en = 4'h1;
      hold(1, 1, 16'h34, 4900);
      wait_for(1, 1, 16'h0, 1400);
      wait_for(0, 1, 16'h0, 50);
      tally_and_finish();
   end
endmodule // buck_channel_sequencer_protect_tb

/* File: verif/buck_host_model.sv */
// Host model that programs the sequencer configuration one write at a time.
`timescale 1ns/1ps
module buck_host_model
   import buck_seq_pkg::*;
(
   input  wire logic    clk,
   output cfg_write_type cfg
);
   initial cfg = '0;

   // One write: fields change after a falling edge and stand for one rising edge.
   task automatic write_reg(input logic [1:0] ch, input logic [2:0] sel, input logic [15:0] data);
      @(negedge clk);
      cfg = '{strobe: 1'b1, channel: ch, select: sel, data: data};
      @(negedge clk);
      cfg.strobe = 1'b0;
      cfg.data = ~data;  // Released data never shows the last value.
   endtask

   // Loads a target from millivolts, even codes from 2.6 V, divider code above 5.1 V.
   task automatic set_target(input logic [1:0] ch, input int mv);
      int code;
      code = mv / TARGET_STEP_MV;
      if (mv > 5100) begin
         code = 'h32;
      end else if (mv >= 2600) begin
         code = code & ~1;
      end
      write_reg(ch, SEL_TARGET, 16'(code));
   endtask
endmodule // buck_host_model

/* File: verif/buck_seq_assertions.sv */
// Concurrent checks on the ports of the channel sequencer.
`timescale 1ns/1ps
module buck_seq_assertions
   import buck_seq_pkg::*;
#(
   parameter int RESTART_WAIT_US = RESTART_US
)(
   input wire logic                       CLK_SYS,
   input wire logic                       SYS_RST,
   input wire logic                       CHIP_ENABLE,
   input wire cfg_write_type              CFG_WRITE,
   input wire logic [NUM_CH-1:0]          CHANNEL_ENABLE,
   input wire logic [NUM_CH-1:0]          ALWAYS_ON,
   input wire logic [NUM_CH*NUM_CH-1:0]   FOLLOW_CONFIG,
   input wire logic [NUM_CH*TARGET_W-1:0] VOLTAGE_SENSE,
   input wire logic [NUM_CH*SENSE_W-1:0]  CURRENT_SENSE,
   input wire logic [NUM_CH-1:0]          FLAG_PIN_ROUTE,
   input wire logic                       CHIP_READY,
   input wire logic [NUM_CH*TARGET_W-1:0] REFERENCE_CODE,
   input wire logic [NUM_CH-1:0]          SWITCHING_ON,
   input wire logic [NUM_CH-1:0]          LOW_SIDE_GATE_DRIVE,
   input wire ch_flags_type [NUM_CH-1:0]  FLAGS,
   input wire logic [NUM_CH-1:0]          FLAG_PIN
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   // Per-channel OR of the three flags, as the pin logic sees it.
   logic [NUM_CH-1:0] any_flag;
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         any_flag[i] = |FLAGS[i];
      end
   end

   // Shutdown steps of channel 0 and of its follower.
   sequence ov_shut;
      ##[0:1] !SWITCHING_ON[0];
   endsequence
   sequence follower_off;
      ##[0:2] !SWITCHING_ON[1];
   endsequence
   sequence sw0_stays_off;
      !SWITCHING_ON[0] [*8];
   endsequence

   ready_follow_a: assert property ($rose(CHIP_ENABLE) |=> CHIP_READY)
      else $error("ready not raised after chip enable");
   gate_cause_a: assert property ($rose(LOW_SIDE_GATE_DRIVE[0]) |->
         !SWITCHING_ON[0] && FLAGS[0].ov_fault)
      else $error("low-side drive raised without an over-voltage stop");
   gate_hold_a: assert property (LOW_SIDE_GATE_DRIVE[0] && CHIP_ENABLE &&
         !(CHANNEL_ENABLE[0] || ALWAYS_ON[0]) |=> LOW_SIDE_GATE_DRIVE[0])
      else $error("low-side drive released without a re-enable");
   ov_stop_a: assert property ($rose(FLAGS[0].ov_fault) |-> ov_shut)
      else $error("over-voltage flag set while channel still switching");
   ov_follow_a: assert property ($rose(FLAGS[0].ov_fault) && FOLLOW_CONFIG[4] |->
         follower_off)
      else $error("follower kept switching after over-voltage stop");
   oc_stop_a: assert property ($rose(FLAGS[0].oc_fault) |-> ##1 sw0_stays_off)
      else $error("switching resumed too early after over-current");
   ramp_step_a: assert property (SWITCHING_ON[0] && $past(SWITCHING_ON[0]) |->
         (REFERENCE_CODE[7:0] - $past(REFERENCE_CODE[7:0])) inside {8'h00, 8'h01, 8'hff})
      else $error("reference moved by more than one step");
   flag_pin_a: assert property (FLAG_PIN == $past(any_flag & FLAG_PIN_ROUTE))
      else $error("flag pin does not follow routed flags");
endmodule // buck_seq_assertions

bind buck_channel_sequencer_protect buck_seq_assertions #(.RESTART_WAIT_US(RESTART_WAIT_US)) chk (
   .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CHIP_ENABLE(CHIP_ENABLE), .CFG_WRITE(CFG_WRITE),
   .CHANNEL_ENABLE(CHANNEL_ENABLE), .ALWAYS_ON(ALWAYS_ON), .FOLLOW_CONFIG(FOLLOW_CONFIG),
   .VOLTAGE_SENSE(VOLTAGE_SENSE), .CURRENT_SENSE(CURRENT_SENSE),
   .FLAG_PIN_ROUTE(FLAG_PIN_ROUTE), .CHIP_READY(CHIP_READY), .REFERENCE_CODE(REFERENCE_CODE),
   .SWITCHING_ON(SWITCHING_ON), .LOW_SIDE_GATE_DRIVE(LOW_SIDE_GATE_DRIVE), .FLAGS(FLAGS),
   .FLAG_PIN(FLAG_PIN));
